// ### design/bvs_consts.vh
// Purpose: constants for the beverage vending sequencer
// Assumes: 10 Hz clock, half-second steps of five clocks
// Notes: output word bit positions and phase lengths in half seconds
`ifndef BVS_CONSTS_VH
`define BVS_CONSTS_VH

`define BVS_CLK_HZ        10
`define BVS_HALF_SEC_CLKS 7'h05
`define BVS_CNT_W         7

// phase lengths in half seconds, sized to the counter width
`define BVS_SETTLE_HS     7'h03
`define BVS_WATER_PRE_HS  7'h02
`define BVS_WATER_TOT_HS  7'h14
`define BVS_COFFEE_HS     7'h05
`define BVS_SOUP_HS       7'h04
`define BVS_CHOC_HS       7'h07
`define BVS_CREAM_HS      7'h04
`define BVS_SUGAR_HS      7'h03
`define BVS_REMOVE_HS     7'h07

// output word bit positions
`define BVS_OUT_W         10
`define BVS_B_BUSY        0
`define BVS_B_CUP         1
`define BVS_B_WATER       2
`define BVS_B_COFFEE      3
`define BVS_B_CREAM       4
`define BVS_B_SUGAR       5
`define BVS_B_CHOC        6
`define BVS_B_SOUP        7
`define BVS_B_REFUND      8
`define BVS_B_CLEAR       9

`endif

// ### design/bvs_countdown.v
// Purpose: phase countdown, loaded with length minus one, done at zero
// Assumes: load happens on the edge that enters the phase
// Notes: a phase of n clocks sees the values n-1 down to zero
`timescale 1ns/10ps
module bvs_countdown #(
	parameter W = 7
) (
	// clock and reset
	input  wire         clock,
	input  wire         rst,
	// control
	input  wire         load,
	input  wire [W-1:0] load_value,
	// status
	output wire         compare_flag
);
	reg [W-1:0] countdown_register;

	always @(posedge clock) begin
		if (rst)
			countdown_register <= {W{1'b0}};
		else if (load)
			countdown_register <= load_value;
		else if (countdown_register != {W{1'b0}})
			countdown_register <= countdown_register - {{(W-1){1'b0}}, 1'b1};
	end

	// check then decrement: zero state is the last clock of the phase
	assign compare_flag = (countdown_register == {W{1'b0}});
endmodule // bvs_countdown

// ### design/bvs_select.v
// Purpose: fixed-priority selection decode
// Assumes: latched request inputs
// Notes: coffee first, then chocolate, soup, coin return
`timescale 1ns/10ps
module bvs_select (
	// requests
	input  wire       coffee_req,
	input  wire       choc_req,
	input  wire       soup_req,
	input  wire       return_req,
	// one-hot grant: coffee, chocolate, soup, return
	output wire [3:0] grant
);
	assign grant[0] = coffee_req;                                  // [RL19]
	assign grant[1] = !coffee_req && choc_req;                     // [RL19]
	assign grant[2] = !coffee_req && !choc_req && soup_req;        // [RL19]
	assign grant[3] = !coffee_req && !choc_req && !soup_req && return_req; // [RL19]
endmodule // bvs_select

// ### design/bvs_sequencer.v
// Purpose: hot-drink vending sequencer driving cup, water, powders, refund
// Assumes: inputs are synchronised and latched outside; 10 Hz clock
// Notes: one state per timed phase; one shared countdown
// Summary of operation
// RL1: idle holds all actuators off until latched coin seen.
// RL2: after coin, light busy and wait for coffee, chocolate, soup, return.
// RL3: coin return pulses refund, drops busy, returns to coin wait.
// RL4: any drink first drops a cup.
// RL5: cup settles 1.5 s before water starts.
// RL6: water runs 1 s before any powder.
// RL7: water on without break for 10 s total on every drink.
// RL8: busy lamp lit from coin until sequence ends.
// RL9: powder time: coffee 2.5 s, soup 2.0 s, chocolate 3.5 s.
// RL10: coffee only: cream 2.0 s and sugar 1.5 s if requested.
// RL11: after water, wait 3.5 s for cup removal before coin test.
// RL12: 10 Hz clock; durations are half seconds of five clocks.
// RL13: outside latches inputs; clear pulse at end of each sequence.
// RL14: phases last exact clocks, load cycle included.
// RL15: final water tops up to ten seconds total.
// RL16: outputs form a ten-bit control word at fixed positions.
// RL17: reset passes one redirect state, then coin wait.
// RL18: seven condition inputs sampled.
// RL19: requests checked every clock: coffee, chocolate, soup, return.
`timescale 1ns/10ps
`include "bvs_consts.vh"
module bvs_sequencer #(
	parameter CNT_W = `BVS_CNT_W
) (
	// clock and reset
	input  wire                  clock,
	input  wire                  rst,
	// latched condition inputs
	input  wire                  coin,
	input  wire                  soup_req,
	input  wire                  choc_req,
	input  wire                  cream_req,
	input  wire                  sugar_req,
	input  wire                  coffee_req,
	input  wire                  return_req,
	// actuator control word
	output reg  [`BVS_OUT_W-1:0] control_word,
	// state view
	output wire                  idle
);
	// states, one-hot
	localparam S_REDIR  = 14'h0001;
	localparam S_ZERO   = 14'h0002;
	localparam S_CLEAR  = 14'h0004;
	localparam S_TEST   = 14'h0008;
	localparam S_CUP    = 14'h0010;
	localparam S_SETTLE = 14'h0020;
	localparam S_PRE    = 14'h0040;
	localparam S_POWDER = 14'h0080;
	localparam S_CREAM  = 14'h0100;
	localparam S_SUGAR  = 14'h0200;
	localparam S_LAST   = 14'h0400;
	localparam S_REMOVE = 14'h0800;
	localparam S_REFUND = 14'h1000;
	localparam S_END    = 14'h2000;

	// drink codes
	localparam D_COFFEE = 2'h0;
	localparam D_CHOC   = 2'h1;
	localparam D_SOUP   = 2'h2;

	// unit step at counter width
	localparam [CNT_W-1:0] ONE = {{(CNT_W-1){1'b0}}, 1'b1};

	reg  [13:0]           state;
	reg  [13:0]           next_state;
	reg  [1:0]            drink;
	reg  [1:0]            next_drink;
	reg  [CNT_W-1:0]      water_on;
	reg                   load;
	reg  [CNT_W-1:0]      load_value;
	reg  [`BVS_OUT_W-1:0] next_control;
	wire                  compare_flag;
	wire [3:0]            grant;

	// clocks for a phase length in half seconds
	function [CNT_W-1:0] clks;
		input [CNT_W-1:0] hs;
		begin
			clks = hs * `BVS_HALF_SEC_CLKS; // [RL12]
		end
	endfunction

	// powder length per drink
	function [CNT_W-1:0] powder_clks;
		input [1:0] d;
		begin
			case (d)
				D_COFFEE: powder_clks = clks(`BVS_COFFEE_HS); // [RL9]
				D_CHOC:   powder_clks = clks(`BVS_CHOC_HS);   // [RL9]
				default:  powder_clks = clks(`BVS_SOUP_HS);   // [RL9]
			endcase
		end
	endfunction

	// length in clocks of the phase being entered
	function [CNT_W-1:0] phase_len;
		input [13:0]      st;
		input [1:0]       d;
		input [CNT_W-1:0] wdone;
		begin
			case (st)
				S_SETTLE: phase_len = clks(`BVS_SETTLE_HS);            // [RL5]
				S_PRE:    phase_len = clks(`BVS_WATER_PRE_HS);         // [RL6]
				S_POWDER: phase_len = powder_clks(d);                  // [RL9]
				S_CREAM:  phase_len = clks(`BVS_CREAM_HS);             // [RL10]
				S_SUGAR:  phase_len = clks(`BVS_SUGAR_HS);             // [RL10]
				S_LAST:   phase_len = clks(`BVS_WATER_TOT_HS) - wdone - ONE; // [RL15]
				S_REMOVE: phase_len = clks(`BVS_REMOVE_HS);            // [RL11]
				default:  phase_len = ONE;
			endcase
		end
	endfunction

	// actuator word shown while in a state
	function [`BVS_OUT_W-1:0] outputs_of;
		input [13:0]          st;
		input [1:0]           d;
		reg   [`BVS_OUT_W-1:0] w;
		begin
			w = {`BVS_OUT_W{1'b0}};
			case (st)
				S_CLEAR: begin
					w[`BVS_B_CLEAR] = 1'b1; // [RL13]
				end
				S_TEST: begin
					w[`BVS_B_BUSY] = 1'b1; // [RL2] [RL8]
				end
				S_CUP: begin
					w[`BVS_B_BUSY] = 1'b1;
					w[`BVS_B_CUP]  = 1'b1; // [RL4]
				end
				S_SETTLE, S_REMOVE: begin
					w[`BVS_B_BUSY] = 1'b1; // [RL5] [RL8] [RL11]
				end
				S_PRE, S_LAST: begin
					w[`BVS_B_BUSY]  = 1'b1;
					w[`BVS_B_WATER] = 1'b1; // [RL6] [RL7]
				end
				S_POWDER: begin
					w[`BVS_B_BUSY]  = 1'b1;
					w[`BVS_B_WATER] = 1'b1; // [RL7]
					case (d)
						D_COFFEE: w[`BVS_B_COFFEE] = 1'b1; // [RL9]
						D_CHOC:   w[`BVS_B_CHOC]   = 1'b1; // [RL9]
						default:  w[`BVS_B_SOUP]   = 1'b1; // [RL9]
					endcase
				end
				S_CREAM: begin
					w[`BVS_B_BUSY]  = 1'b1;
					w[`BVS_B_WATER] = 1'b1;
					w[`BVS_B_CREAM] = 1'b1; // [RL10]
				end
				S_SUGAR: begin
					w[`BVS_B_BUSY]  = 1'b1;
					w[`BVS_B_WATER] = 1'b1;
					w[`BVS_B_SUGAR] = 1'b1; // [RL10]
				end
				S_REFUND: begin
					// busy stays for this one pulse, goes dark after
					w[`BVS_B_BUSY]   = 1'b1;
					w[`BVS_B_REFUND] = 1'b1; // [RL3]
					w[`BVS_B_CLEAR]  = 1'b1; // [RL13]
				end
				S_END: begin
					w[`BVS_B_CLEAR] = 1'b1; // [RL13]
				end
				default: begin
					w = {`BVS_OUT_W{1'b0}}; // [RL1]
				end
			endcase
			outputs_of = w;
		end
	endfunction

	bvs_countdown #(
		.W (CNT_W)
	) u_count (
		.clock        (clock),
		.rst          (rst),
		.load         (load),
		.load_value   (load_value),
		.compare_flag (compare_flag)
	);

	bvs_select u_sel (
		.coffee_req (coffee_req),
		.choc_req   (choc_req),
		.soup_req   (soup_req),
		.return_req (return_req),
		.grant      (grant)
	);

	// the countdown is loaded on the edge that enters a timed phase,
	// so the phase sees n-1 down to zero: exactly n clocks
	always @* begin
		next_state = state;
		next_drink = drink;
		load       = 1'b0;
		case (state)
			S_REDIR: begin
				next_state = S_ZERO; // [RL17]
			end
			S_ZERO: begin
				// all actuators off while waiting
				if (coin) begin // [RL1] [RL18]
					next_state = S_CLEAR;
				end
			end
			S_CLEAR: begin
				next_state = S_TEST; // [RL2]
			end
			S_TEST: begin
				// stays here and re-checks every clock
				if (grant[0] | grant[1] | grant[2]) begin // [RL19]
					next_state = S_CUP; // [RL4]
					next_drink = grant[0] ? D_COFFEE : (grant[1] ? D_CHOC : D_SOUP);
				end else if (grant[3]) begin
					next_state = S_REFUND; // [RL3]
				end
			end
			S_CUP: begin
				next_state = S_SETTLE; // [RL5]
				load       = 1'b1;
			end
			S_SETTLE: begin
				if (compare_flag) begin
					next_state = S_PRE; // [RL6]
					load       = 1'b1;
				end
			end
			S_PRE: begin
				if (compare_flag) begin
					next_state = S_POWDER; // [RL9]
					load       = 1'b1;
				end
			end
			S_POWDER: begin
				if (compare_flag) begin
					load = 1'b1;
					if (drink == D_COFFEE && cream_req) begin // [RL10]
						next_state = S_CREAM;
					end else if (drink == D_COFFEE && sugar_req) begin // [RL10]
						next_state = S_SUGAR;
					end else begin
						next_state = S_LAST;
					end
				end
			end
			S_CREAM: begin
				if (compare_flag) begin
					load = 1'b1;
					if (sugar_req) begin // [RL10]
						next_state = S_SUGAR;
					end else begin
						next_state = S_LAST;
					end
				end
			end
			S_SUGAR: begin
				if (compare_flag) begin
					next_state = S_LAST; // [RL15]
					load       = 1'b1;
				end
			end
			S_LAST: begin
				if (compare_flag) begin
					next_state = S_REMOVE; // [RL11]
					load       = 1'b1;
				end
			end
			S_REMOVE: begin
				if (compare_flag) begin
					next_state = S_END; // [RL13]
				end
			end
			S_REFUND, S_END: begin
				next_state = S_ZERO; // [RL3] [RL13]
			end
			default: begin
				next_state = S_ZERO;
			end
		endcase
		load_value   = phase_len(next_state, next_drink, water_on) - ONE; // [RL14]
		next_control = outputs_of(next_state, next_drink); // [RL16]
	end

	// clocks of water already run before the current one;
	// limitation: the whole water time must fit the counter width
	always @(posedge clock) begin
		if (rst)
			water_on <= {CNT_W{1'b0}};
		else if (control_word[`BVS_B_WATER])
			water_on <= water_on + ONE; // [RL7] [RL15]
		else
			water_on <= {CNT_W{1'b0}};
	end

	// word registered with the state, so it always matches it
	always @(posedge clock) begin
		if (rst) begin
			state        <= S_REDIR; // [RL17]
			drink        <= D_COFFEE;
			control_word <= {`BVS_OUT_W{1'b0}};
		end else begin
			state        <= next_state;
			drink        <= next_drink;
			control_word <= next_control; // [RL16]
		end
	end

	assign idle = (state == S_ZERO);
endmodule // bvs_sequencer

// ### verification/bvs_latch_model.sv
// Purpose: model of the outside input latches
// Assumes: presses are one-clock pulses
// Notes: bit order coin, soup, choc, cream, sugar, coffee, return
`timescale 1ns/10ps
module bvs_latch_model (
	// clock and reset
	input  wire       clock,
	input  wire       rst,
	// presses and clear
	input  wire [6:0] press,
	input  wire       clear,
	// latched levels
	output reg  [6:0] held
);
	// a press landing on the clear edge is lost, as in real latches
	always @(posedge clock) begin
		if (rst || clear)
			held <= 7'h00;
		else
			held <= held | press;
	end
endmodule // bvs_latch_model

// ### verification/bvs_assertions.sv
// Purpose: port checker for the sequencer
// Assumes: one clock, synchronous reset
// Notes: lengths in clocks, load clock counted
`timescale 1ns/10ps
module bvs_checker (
	input wire       clock,
	input wire       rst,
	input wire       coin,
	input wire [9:0] control_word,
	input wire       idle
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	wire [9:0] cw = control_word;
	reg  [7:0] wrun;
	// run length of water, zero while off
	always @(posedge clock) begin
		if (rst || !cw[2])
			wrun <= 8'h00;
		else
			wrun <= wrun + 8'h01;
	end
	a_idle_all_off: assert property (idle |-> cw == 10'h000)
		else $error("actuator on while idle");
	a_coin_clear: assert property (idle && coin |-> ##[1:2] cw[9])
		else $error("no clear after coin");
	a_refund_then_off: assert property (cw[8] |-> cw[9] && cw[0] ##1 cw == 10'h000)
		else $error("bad coin return");
	a_cup_settle: assert property ($rose(cw[1]) |=> (!cw[1] && !cw[2])[*8] ##[7:8] $rose(cw[2]))
		else $error("cup settle wrong");
	a_water_lead: assert property ($rose(cw[3] | cw[6] | cw[7]) |-> $past(cw[2], 10) && !$past(cw[2], 11))
		else $error("water lead wrong");
	a_water_total: assert property ($fell(cw[2]) |-> wrun == 8'h64)
		else $error("water total wrong");
	a_busy_span: assert property ((|cw[8:1]) |-> cw[0])
		else $error("busy off mid sequence");
	a_coffee_len: assert property ($fell(cw[3]) |-> $past(cw[3], 25) && !$past(cw[3], 26))
		else $error("coffee length wrong");
	a_one_powder: assert property ($onehot0({cw[7], cw[6], cw[3]}))
		else $error("two powders on");
	a_reset_redirect: assert property ($fell(rst) |-> !idle ##1 idle)
		else $error("no redirect state");
	cover property ($fell(cw[3]));
	cover property ($fell(cw[6]));
	cover property ($fell(cw[7]));
	cover property ($rose(cw[8]));
endmodule // bvs_checker
bind bvs_sequencer bvs_checker chk (.clock(clock), .rst(rst), .coin(coin), .control_word(control_word), .idle(idle));

// ### verification/bvs_tb.sv
// Purpose: self-checking bench for the sequencer
// Assumes: latch model in front of the inputs
// Notes: pulse lengths measured by a run monitor
`timescale 1ns/10ps
module tb;
	reg        clock = 1'b0;
	reg        rst = 1'b1;
	reg  [6:0] press = 7'h00;
	wire [6:0] held;
	wire [9:0] cw;
	wire       idle;
	integer    miscompares = 0;
	integer    n_tests = 0;
	integer    cyc = 0;
	integer    run [0:9];
	integer    last [0:9];
	integer    i;
	always #10 clock = ~clock;
	bvs_latch_model lm (.clock(clock), .rst(rst), .press(press), .clear(cw[9]), .held(held));
	bvs_sequencer uut (.clock(clock), .rst(rst), .coin(held[0]), .soup_req(held[1]), .choc_req(held[2]),
		.cream_req(held[3]), .sugar_req(held[4]), .coffee_req(held[5]), .return_req(held[6]),
		.control_word(cw), .idle(idle));
	task give_verdict;
		begin
			if (miscompares == 0 && n_tests > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask
	// monitor, also the hang guard
	always @(posedge clock) begin
		cyc = cyc + 1;
		if (cyc == 4000) begin
			miscompares = miscompares + 1;
			give_verdict;
		end
		for (i = 0; i < 10; i = i + 1) begin
			if (cw[i] === 1'b1)
				run[i] = run[i] + 1;
			else if (run[i] != 0) begin
				last[i] = run[i];
				run[i] = 0;
			end
		end
	end
	task chk_len(input string nm, input integer b, input integer e);
		begin
			n_tests = n_tests + 1;
			if (last[b] != e) begin
				miscompares = miscompares + 1;
				$display("BAD %0s exp %0d got %0d", nm, e, last[b]);
			end
		end
	endtask
	task chk_val(input string nm, input [9:0] e, input [9:0] g);
		begin
			n_tests = n_tests + 1;
			if (g !== e) begin
				miscompares = miscompares + 1;
				$display("BAD %0s exp %h got %h", nm, e, g);
			end
		end
	endtask
	task push(input [6:0] m);
		begin
			@(negedge clock);
			press = m;
			@(negedge clock);
			press = 7'h00;
		end
	endtask
	// coin, wait for the clear, then buttons; waits bounded
	task vend(input [6:0] sel, input integer cf, cr, sg, ch, sp, wt, rf, cp);
		integer k;
		begin
			for (k = 0; k < 10; k = k + 1)
				last[k] = 0;
			push(7'h01);
			for (k = 0; k < 20 && cw[9] !== 1'b1; k = k + 1)
				@(negedge clock);
			repeat (2) @(negedge clock);
			push(sel);
			for (k = 0; k < 400 && idle !== 1'b1; k = k + 1)
				@(negedge clock);
			repeat (2) @(negedge clock);
			chk_len("coffee", 3, cf);
			chk_len("cream", 4, cr);
			chk_len("sugar", 5, sg);
			chk_len("choc", 6, ch);
			chk_len("soup", 7, sp);
			chk_len("water", 2, wt);
			chk_len("refund", 8, rf);
			chk_len("cup", 1, cp);
			chk_len("clear", 9, 1);
		end
	endtask
	initial begin
		for (i = 0; i < 10; i = i + 1) begin
			run[i] = 0;
			last[i] = 0;
		end
		repeat (3) @(negedge clock);
		rst = 1'b0;
		repeat (3) @(negedge clock);
		push(7'h20);
		repeat (20) @(negedge clock);
		chk_val("word", 10'h000, cw);
		chk_val("idle", 10'h001, {9'h000, idle});
		vend(7'h24, 25, 0, 0, 0, 0, 100, 0, 1);
		vend(7'h38, 25, 20, 15, 0, 0, 100, 0, 1);
		vend(7'h0C, 0, 0, 0, 35, 0, 100, 0, 1);
		vend(7'h02, 0, 0, 0, 0, 20, 100, 0, 1);
		vend(7'h40, 0, 0, 0, 0, 0, 0, 1, 0);
		give_verdict;
	end
endmodule // tb
